// >>> pkg/bbsr_defs.vh
// Register map, field layout, reset values and timing counts of the converter control block
`ifndef BBSR_DEFS_VH
`define BBSR_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BBSR_ADDR_BB_CTRL 8'h19
`define BBSR_ADDR_RAMP_CTRL 8'h1A

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BBSR_RST_BB_CTRL 8'h94
`define BBSR_RST_RAMP_CTRL 8'h06
`define BBSR_RST_BB_SKIP 1'h1
`define BBSR_RST_BB_VCODE 6'h14
`define BBSR_RST_RATE 3'h6
`define BBSR_RST_BB_MV 12'h708

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BBSR_BB_SKIP_BIT 7
`define BBSR_BB_VCODE_MSB 5
`define BBSR_RC_TRIG_BIT 7
`define BBSR_RC_BYPASS_BIT 6
`define BBSR_RC_RATE_MSB 2

// ----------------------------------------------------------------
// Voltage code map, in millivolts
// ----------------------------------------------------------------
`define BBSR_FINE_BASE_MV 12'h497
`define BBSR_FINE_STEP_MV 12'h019
`define BBSR_COARSE_BASE_MV 12'h640
`define BBSR_COARSE_STEP_MV 12'h032
`define BBSR_COARSE_FIRST 6'h10
`define BBSR_CODE_LAST 6'h34

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BBSR_CLK_PERIOD_NS 100
`define BBSR_BLANK_TIME_MS 5
`define BBSR_BLANK_CYCLES ((`BBSR_BLANK_TIME_MS * 1000000) / `BBSR_CLK_PERIOD_NS)
`define BBSR_STEP_SLOW_NS 160000
`define BBSR_STEP_SLOW_CYCLES (`BBSR_STEP_SLOW_NS / `BBSR_CLK_PERIOD_NS)
`define BBSR_RATE_IMMEDIATE 3'h7

`endif

// >>> core/bbsr_ramp.v
// Stepping engine that walks the two main step-down setpoints toward their targets
`timescale 1ns/1ps
`include "bbsr_defs.vh"

module bbsr_ramp #(
	parameter CODE_W = 6,
	parameter CNT_W = 12
)(
	input wire ref_clk,
	input wire rstn,
	input wire start,
	input wire [2:0] rate,
	input wire [CODE_W-1:0] tgt_one,
	input wire [CODE_W-1:0] tgt_two,
	output reg [CODE_W-1:0] cur_one_r,
	output reg [CODE_W-1:0] cur_two_r,
	output reg busy_r,
	output reg done_r
);

	// ----------------------------------------------------------------
	// Step timer
	// ----------------------------------------------------------------
	// Slowest step length is cut to the counter width on purpose
	localparam integer SLOW_INT = `BBSR_STEP_SLOW_CYCLES;
	localparam [CNT_W-1:0] SLOW_CYC = SLOW_INT[CNT_W-1:0];
	reg [CNT_W-1:0] tick_cnt_r;
	reg [CODE_W-1:0] tgt_one_r;
	reg [CODE_W-1:0] tgt_two_r;
	wire [CNT_W-1:0] step_cyc;
	wire immediate;
	wire tick;
	wire [1:0] at_tgt;

	// Each rate code from 1 to 6 halves the step time of the code below it, starting from the slowest code 0
	assign step_cyc = SLOW_CYC >> rate;
	assign immediate = (rate == `BBSR_RATE_IMMEDIATE);
	assign tick = busy_r && (immediate || tick_cnt_r >= step_cyc - 12'h001);

	// Counter restarts on every start so a retarget gets a whole step
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			tick_cnt_r <= 12'h000;
		else if (start || tick || !busy_r)
			tick_cnt_r <= 12'h000;
		else
			tick_cnt_r <= tick_cnt_r + 12'h001;
	end

	// ----------------------------------------------------------------
	// Per-converter stepping
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : chan
			wire [CODE_W-1:0] tgt;
			wire [CODE_W-1:0] cur;
			assign tgt = (g == 0) ? tgt_one_r : tgt_two_r;
			assign cur = (g == 0) ? cur_one_r : cur_two_r;
			assign at_tgt[g] = (cur == tgt);
		end
	endgenerate

	// Targets latched at start; a change on the inputs mid-ramp waits for the next start
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tgt_one_r <= `BBSR_RST_BB_VCODE;
			tgt_two_r <= `BBSR_RST_BB_VCODE;
			cur_one_r <= `BBSR_RST_BB_VCODE;
			cur_two_r <= `BBSR_RST_BB_VCODE;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (start)
			begin
				tgt_one_r <= tgt_one;
				tgt_two_r <= tgt_two;
				busy_r <= 1'b1;
			end
			else if (busy_r && (&at_tgt))
			begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end
			else if (tick)
			begin
				// Immediate rate jumps straight, otherwise one code per step
				if (immediate)
				begin
					cur_one_r <= tgt_one_r;
					cur_two_r <= tgt_two_r;
				end
				else
				begin
					if (!at_tgt[0])
						cur_one_r <= (cur_one_r < tgt_one_r) ? cur_one_r + 6'h01 : cur_one_r - 6'h01;
					if (!at_tgt[1])
						cur_two_r <= (cur_two_r < tgt_two_r) ? cur_two_r + 6'h01 : cur_two_r - 6'h01;
				end
			end
		end
	end

endmodule

// >>> core/bbsr_regs.v
// Buck-boost setpoint register and ramp control register with their side effects
//
// Overview of operation
// - The buck-boost control register sits at subaddress 19h and resets to 94h.
// - Writes to the buck-boost register only land while the protection scheme unlocks it.
// - Every accepted write to the buck-boost register blanks its voltage monitors for 5 ms.
// - Bit 7 of the buck-boost register enables pulse skipping at light load, reset 1.
// - Bits 5..0 are the voltage code, reset 14h, 25 mV steps from 1.175 V then 50 mV from 1.6 V.
// - The power-up voltage code may be replaced by a strap-selected value.
// - The ramp control register sits at subaddress 1Ah and resets to 06h.
// - The ramp rate acts on the two main step-down converters only.
// - Writing 1 to bit 7 of the ramp register ramps both main converters to their setpoints.
// - The trigger bit clears itself when the transition completes.
// - Bit 6 bypasses the trigger so each setpoint update ramps at once, reset 0.
// - Bits 2..0 pick 160 us per step halved per code down to 2.5 us, with 7 immediate.
`timescale 1ns/1ps
`include "bbsr_defs.vh"

module bbsr_regs #(
	parameter BLANK_CYCLES = `BBSR_BLANK_CYCLES,
	parameter CODE_W = 6
)(
	input wire ref_clk,
	input wire rstn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire prot_unlock,
	input wire strap_default_select,
	input wire [CODE_W-1:0] strap_vcode,
	input wire [CODE_W-1:0] sd1_setpoint,
	input wire [CODE_W-1:0] sd2_setpoint,
	input wire setpoint_update,
	output reg [7:0] reg_rdata_r,
	output reg light_load_skip_enable_r,
	output reg [CODE_W-1:0] bb_vcode_r,
	output reg [11:0] bb_mv_r,
	output reg bb_code_reserved_r,
	output reg bb_mon_blank_r,
	output wire [CODE_W-1:0] sd1_vcode_r,
	output wire [CODE_W-1:0] sd2_vcode_r,
	output wire ramp_busy_r
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	// Window end is worked out as an integer and cut to the counter width on purpose
	localparam integer BLANK_LAST_INT = BLANK_CYCLES - 1;
	localparam [16:0] BLANK_LAST = BLANK_LAST_INT[16:0];
	reg trig_r;
	reg bypass_r;
	reg [2:0] rate_r;
	reg [16:0] blank_cnt_r;
	reg [16:0] blank_cnt_nxt;
	reg strap_done_r;
	reg [7:0] rdata_nxt;
	reg [11:0] mv_nxt;
	wire bb_wr;
	wire rc_wr;
	wire bb_wr_ok;
	wire trig_set;
	wire ramp_start;
	wire ramp_done;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign bb_wr = reg_wr && (reg_addr == `BBSR_ADDR_BB_CTRL);
	assign rc_wr = reg_wr && (reg_addr == `BBSR_ADDR_RAMP_CTRL);
	// Locked writes are dropped silently, no side effects at all
	assign bb_wr_ok = bb_wr && prot_unlock;

	// ----------------------------------------------------------------
	// Buck-boost control register
	// ----------------------------------------------------------------
	// Strap value is taken one cycle after reset release, never inside reset
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			light_load_skip_enable_r <= `BBSR_RST_BB_SKIP;
			bb_vcode_r <= `BBSR_RST_BB_VCODE;
			strap_done_r <= 1'b0;
		end
		else
		begin
			strap_done_r <= 1'b1;
			if (bb_wr_ok)
			begin
				light_load_skip_enable_r <= reg_wdata[`BBSR_BB_SKIP_BIT];
				// Bit 6 is dropped here so it always reads zero
				bb_vcode_r <= reg_wdata[`BBSR_BB_VCODE_MSB:0];
			end
			else if (!strap_done_r && strap_default_select)
				bb_vcode_r <= strap_vcode;
		end
	end

	// ----------------------------------------------------------------
	// Voltage decode of the buck-boost code
	// ----------------------------------------------------------------
	// Two-segment map; reserved codes are flagged, not clamped, so misuse is visible
	always @*
	begin
		mv_nxt = 12'h000;
		if (bb_vcode_r < `BBSR_COARSE_FIRST)
			mv_nxt = `BBSR_FINE_BASE_MV + `BBSR_FINE_STEP_MV * {6'h00, bb_vcode_r};
		else
			mv_nxt = `BBSR_COARSE_BASE_MV
				+ `BBSR_COARSE_STEP_MV * {6'h00, bb_vcode_r - `BBSR_COARSE_FIRST};
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bb_mv_r <= `BBSR_RST_BB_MV;
			bb_code_reserved_r <= 1'b0;
		end
		else
		begin
			bb_mv_r <= mv_nxt;
			bb_code_reserved_r <= (bb_vcode_r > `BBSR_CODE_LAST);
		end
	end

	// ----------------------------------------------------------------
	// Monitor blanking after a buck-boost write
	// ----------------------------------------------------------------
	// A fresh write restarts the full window rather than extending the old one
	always @*
	begin
		blank_cnt_nxt = blank_cnt_r;
		if (bb_wr_ok)
			blank_cnt_nxt = BLANK_LAST;
		else if (blank_cnt_r != 17'h00000)
			blank_cnt_nxt = blank_cnt_r - 17'h00001;
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blank_cnt_r <= 17'h00000;
			bb_mon_blank_r <= 1'b0;
		end
		else
		begin
			blank_cnt_r <= blank_cnt_nxt;
			bb_mon_blank_r <= bb_wr_ok || (blank_cnt_r != 17'h00000);
		end
	end

	// ----------------------------------------------------------------
	// Ramp control register
	// ----------------------------------------------------------------
	assign trig_set = rc_wr && reg_wdata[`BBSR_RC_TRIG_BIT];
	// Bypass lets every setpoint update start a ramp without the trigger
	assign ramp_start = trig_set || (bypass_r && setpoint_update);

	// Trigger set wins over the self-clear when both land together
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			trig_r <= 1'b0;
			bypass_r <= 1'b0;
			rate_r <= `BBSR_RST_RATE;
		end
		else
		begin
			if (trig_set)
				trig_r <= 1'b1;
			else if (ramp_done)
				trig_r <= 1'b0;
			if (rc_wr)
			begin
				bypass_r <= reg_wdata[`BBSR_RC_BYPASS_BIT];
				rate_r <= reg_wdata[`BBSR_RC_RATE_MSB:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Ramp engine for the main step-down converters
	// ----------------------------------------------------------------
	// The buck-boost code above bypasses this engine entirely
	bbsr_ramp #(
		.CODE_W(CODE_W),
		.CNT_W(12)
	) u_ramp (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.start(ramp_start),
		.rate(rate_r),
		.tgt_one(sd1_setpoint),
		.tgt_two(sd2_setpoint),
		.cur_one_r(sd1_vcode_r),
		.cur_two_r(sd2_vcode_r),
		.busy_r(ramp_busy_r),
		.done_r(ramp_done)
	);

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	// Unmapped subaddresses read zero; other registers live outside this block
	always @*
	begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`BBSR_ADDR_BB_CTRL:
				rdata_nxt = {light_load_skip_enable_r, 1'b0, bb_vcode_r};
			`BBSR_ADDR_RAMP_CTRL:
				rdata_nxt = {trig_r, bypass_r, 3'h0, rate_r};
			default:
				rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
			reg_rdata_r <= rdata_nxt;
	end

endmodule

// >>> sim/bbsr_host.sv
// Host model that drives the register port of the converter control block
`timescale 1ns/1ps
`include "bbsr_defs.vh"

module bbsr_host (
	input wire ref_clk,
	input wire [7:0] reg_rdata_r,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// Port idle from time zero, so nothing is asked during reset
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One strobe per byte; data is scrambled after the taking edge so stale values never match
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// The buck-boost converter is taken as stopped whenever its code is rewritten
		if (a == `BBSR_ADDR_BB_CTRL && v[5:0] > `BBSR_CODE_LAST)
			v[5:0] = `BBSR_CODE_LAST; // Never program a reserved code
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
	endtask

	// Read data is taken just after the edge that takes the strobe
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_r;
	endtask
endmodule

// >>> sim/bbsr_regs_monitor.sv
// Concurrent checks on the ports of the converter control register block
`timescale 1ns/1ps
`include "bbsr_defs.vh"

module bbsr_regs_monitor #(
	parameter BLANK_CYCLES = 50000,
	parameter CODE_W = 6
)(
	input wire ref_clk,
	input wire rstn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire prot_unlock,
	input wire strap_default_select,
	input wire [CODE_W-1:0] strap_vcode,
	input wire [CODE_W-1:0] sd1_setpoint,
	input wire [CODE_W-1:0] sd2_setpoint,
	input wire setpoint_update,
	input wire [7:0] reg_rdata_r,
	input wire light_load_skip_enable_r,
	input wire [CODE_W-1:0] bb_vcode_r,
	input wire [11:0] bb_mv_r,
	input wire bb_code_reserved_r,
	input wire bb_mon_blank_r,
	input wire [CODE_W-1:0] sd1_vcode_r,
	input wire [CODE_W-1:0] sd2_vcode_r,
	input wire ramp_busy_r
);
	localparam logic [7:0] A_BB = `BBSR_ADDR_BB_CTRL;
	localparam logic [7:0] A_RC = `BBSR_ADDR_RAMP_CTRL;
	logic [31:0] blank_cnt_r;

	// Millivolts of a legal code: fine steps first, then coarse
	function automatic logic [11:0] code_mv(input logic [CODE_W-1:0] c);
		if (c < 6'h10)
			return 12'h497 + 12'h019 * c;
		return 12'h640 + 12'h032 * (c - 6'h10);
	endfunction

	// Cycles left of blanking; a rewrite restarts the window
	always @(posedge ref_clk or negedge rstn)
		if (!rstn)
			blank_cnt_r <= 32'h0;
		else if (reg_wr && reg_addr == A_BB && prot_unlock)
			blank_cnt_r <= BLANK_CYCLES;
		else if (blank_cnt_r != 32'h0)
			blank_cnt_r <= blank_cnt_r - 32'h1;

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence bb_wr_s;
		reg_wr && reg_addr == A_BB && prot_unlock;
	endsequence
	sequence trig_wr_s;
		reg_wr && reg_addr == A_RC && reg_wdata[7];
	endsequence

	blank_len_a: assert property (bb_mon_blank_r == (blank_cnt_r != 32'h0))
		else $error("blanking window wrong");
	bb_write_a: assert property (bb_wr_s |=>
		{light_load_skip_enable_r, 1'b0, bb_vcode_r} == ($past(reg_wdata) & 8'hBF))
		else $error("buck-boost write lost");
	locked_a: assert property (reg_wr && reg_addr == A_BB && !prot_unlock && !bb_mon_blank_r
		|=> !bb_mon_blank_r && $stable(light_load_skip_enable_r))
		else $error("locked write took effect");
	mv_decode_a: assert property (bb_vcode_r <= 6'h34 |=> bb_mv_r == code_mv($past(bb_vcode_r)))
		else $error("millivolt decode wrong");
	resv_flag_a: assert property (1'b1 |=> bb_code_reserved_r == ($past(bb_vcode_r) > 6'h34))
		else $error("reserved code flag wrong");
	rd_bb_a: assert property (reg_rd && reg_addr == A_BB |=>
		reg_rdata_r == {$past(light_load_skip_enable_r), 1'b0, $past(bb_vcode_r)})
		else $error("buck-boost readback wrong");
	rd_other_a: assert property (reg_rd && reg_addr != A_BB && reg_addr != A_RC |=> reg_rdata_r == 8'h00)
		else $error("unmapped read not zero");
	rd_ramp_a: assert property (reg_rd && reg_addr == A_RC |=> reg_rdata_r[5:3] == 3'h0)
		else $error("ramp reserved bits not zero");
	trig_start_a: assert property (trig_wr_s |=> ramp_busy_r)
		else $error("trigger did not start ramp");
	quiet_hold_a: assert property (!ramp_busy_r && !setpoint_update && !(reg_wr && reg_addr == A_RC && reg_wdata[7])
		|=> $stable(sd1_vcode_r) && $stable(sd2_vcode_r))
		else $error("setpoint moved without ramp");
endmodule

bind bbsr_regs bbsr_regs_monitor #(.BLANK_CYCLES(BLANK_CYCLES), .CODE_W(CODE_W)) bbsr_regs_monitor_i (
	.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .prot_unlock(prot_unlock),
	.strap_default_select(strap_default_select), .strap_vcode(strap_vcode),
	.sd1_setpoint(sd1_setpoint), .sd2_setpoint(sd2_setpoint), .setpoint_update(setpoint_update),
	.reg_rdata_r(reg_rdata_r), .light_load_skip_enable_r(light_load_skip_enable_r),
	.bb_vcode_r(bb_vcode_r), .bb_mv_r(bb_mv_r), .bb_code_reserved_r(bb_code_reserved_r),
	.bb_mon_blank_r(bb_mon_blank_r), .sd1_vcode_r(sd1_vcode_r), .sd2_vcode_r(sd2_vcode_r),
	.ramp_busy_r(ramp_busy_r));

// >>> sim/testbench.sv
// Self-checking bench for the converter control register block
`timescale 1ns/1ps
`include "bbsr_defs.vh"

module testbench;
	localparam int BLANK = 20;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic unlock = 1'b1;
	logic strap_sel = 1'b0;
	logic [5:0] strap = 6'h00;
	logic [5:0] sp1 = 6'h14;
	logic [5:0] sp2 = 6'h14;
	logic upd = 1'b0;
	logic [7:0] ra, wd, rdat;
	logic wr, rs, skip, resv, blank, busy;
	logic [5:0] vc, s1, s2;
	logic [11:0] mv;
	int bad_count = 0;
	int num_checks = 0;

	bbsr_host host_i (.ref_clk(ref_clk), .reg_rdata_r(rdat), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rs));
	bbsr_regs #(.BLANK_CYCLES(BLANK), .CODE_W(6)) bbsr_regs_i (.ref_clk(ref_clk), .rstn(rstn),
		.reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rs), .prot_unlock(unlock),
		.strap_default_select(strap_sel), .strap_vcode(strap), .sd1_setpoint(sp1),
		.sd2_setpoint(sp2), .setpoint_update(upd), .reg_rdata_r(rdat),
		.light_load_skip_enable_r(skip), .bb_vcode_r(vc), .bb_mv_r(mv),
		.bb_code_reserved_r(resv), .bb_mon_blank_r(blank), .sd1_vcode_r(s1),
		.sd2_vcode_r(s2), .ramp_busy_r(busy));

	// 10 MHz clock
	initial
		forever #50 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] exp_mv(input logic [5:0] c);
		if (c < 6'h10)
			return 12'h497 + 12'h019 * c;
		return 12'h640 + 12'h032 * (c - 6'h10);
	endfunction

	// Bounded wait for the ramp to finish; returns the edges it took
	task automatic wait_idle(output int n);
		n = 0;
		#1;
		while (busy !== 1'b0 && n < 4000)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask

	task automatic pulse_upd();
		@(posedge ref_clk);
		upd <= 1'b1;
		@(posedge ref_clk);
		upd <= 1'b0;
		#1;
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard, well beyond the slowest ramp sequence
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		finish_test();
	end

	// Main sequence: defaults, lock, random writes, ramps at every rate, bypass, strap
	initial
	begin
		logic [7:0] d, w;
		logic [5:0] t1, t2;
		int n;
		void'($urandom(95));
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		host_i.read_reg(8'h19, d);
		check(d, 8'h94);
		check(mv, 12'h708);
		host_i.read_reg(8'h1A, d);
		check(d, 8'h06);
		host_i.read_reg(8'h55, d);
		check(d, 8'h00);
		unlock <= 1'b0;
		host_i.write_reg(8'h19, 8'h05);
		#1;
		check(blank, 1'b0);
		host_i.read_reg(8'h19, d);
		check(d, 8'h94);
		unlock <= 1'b1;
		repeat (6)
		begin
			w = 8'($urandom());
			w[5:0] = 6'($urandom_range(0, 6'h34));
			host_i.write_reg(8'h19, w);
			#1;
			check(blank, 1'b1);
			host_i.read_reg(8'h19, d);
			check(d, w & 8'hBF);
			check(mv, exp_mv(w[5:0]));
		end
		repeat (BLANK) @(posedge ref_clk);
		#1;
		check(blank, 1'b0);
		host_i.write_reg(8'h1A, 8'h3F);
		host_i.read_reg(8'h1A, d);
		check(d, 8'h07);
		sp1 <= 6'h16;
		sp2 <= 6'h12;
		host_i.write_reg(8'h1A, 8'h86);
		host_i.read_reg(8'h1A, d);
		check(d, 8'h86);
		wait_idle(n);
		// Two steps of 25 edges each, then one edge for busy to drop
		check(12'(n + 2), 12'(2 * (1600 >> 6) + 1));
		check({s1, s2}, {6'h16, 6'h12});
		check(vc, w[5:0]);
		host_i.read_reg(8'h1A, d);
		check(d, 8'h06);
		for (int r = 0; r < 8; r++)
		begin
			t1 = s1 + 6'h01;
			// Tight monitoring is taken as off, so lowering needs no skip-enable clear
			t2 = s2 - 6'h01;
			sp1 <= t1;
			sp2 <= t2;
			host_i.write_reg(8'h1A, {5'h10, 3'(r)});
			wait_idle(n);
			// A single step lands after its step time, busy drops one edge later
			if (r < 7)
				check(12'(n), 12'((1600 >> r) + 1));
			else
				check(12'(n), 12'h002);
			check({s1, s2}, {t1, t2});
		end
		t1 = s1;
		sp1 <= s1 + 6'h02;
		pulse_upd();
		check({busy, s1}, {1'b0, t1});
		host_i.write_reg(8'h1A, 8'h47);
		t1 = 6'($urandom_range(0, 6'h34));
		t2 = 6'($urandom_range(0, 6'h34));
		sp1 <= t1;
		sp2 <= t2;
		pulse_upd();
		check(busy, 1'b1);
		wait_idle(n);
		check({s1, s2}, {t1, t2});
		host_i.read_reg(8'h1A, d);
		check(d, 8'h47);
		// Corner: a reserved strap code must show up on the reserved flag
		strap <= 6'($urandom_range(6'h35, 6'h3F));
		strap_sel <= 1'b1;
		rstn <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		host_i.read_reg(8'h19, d);
		check(d, {2'h2, strap});
		check(resv, 1'b1);
		finish_test();
	end
endmodule
